// ==== rtl/nand_host.sv ====
// nand flash host: sequences command, address and data cycles on the pins
// assumes pins are synchronous to clk_sys; ready_busy_n is pulled up outside
`timescale 1ns/1ps
`default_nettype none
module nand_host
	import nand_host_pkg::*;
#(
	parameter int unsigned LEN_W = 13
) (
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// user request port
	input  wire logic             req_valid,
	output logic                  req_ready,
	input  wire op_t              req_op,
	input  wire logic [COL_W-1:0] req_col,
	input  wire logic [ROW_W-1:0] req_row,
	input  wire logic [LEN_W-1:0] req_len,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [7:0]       wr_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [7:0]            rd_data,
	output logic                  done,
	input  wire logic             guard_enable,
	// flash pins
	output logic                  chip_select_n,
	output logic                  command_latch_strobe,
	output logic                  address_latch_strobe,
	output logic                  write_strobe_n,
	output logic                  read_strobe_n,
	output logic                  write_guard_n,
	input  wire logic             ready_busy_n,
	input  wire logic [7:0]       io_in,
	output logic [7:0]            io_out,
	output logic                  io_oe_n
);
	typedef enum logic [3:0] {
		S_IDLE, S_CMD1, S_ADDR, S_DATA_IN, S_CMD2, S_WAIT_BUSY, S_WAIT_READY,
		S_DATA_OUT, S_FINISH
	} st_t;
	typedef enum logic [1:0] { K_CMD, K_ADDR, K_DIN, K_DOUT } kind_t;

	st_t               st_q, st_d;
	op_t               op_q, op_d;
	logic [COL_W-1:0]  col_q, col_d;
	logic [ROW_W-1:0]  row_q, row_d;
	logic [LEN_W-1:0]  len_q, len_d;
	logic [2:0]        idx_q, idx_d;
	logic [2:0]        aend_q, aend_d;
	logic [7:0]        out_q, out_d;
	logic              cs_n_q, cs_n_d, cle_q, cle_d, ale_q, ale_d;
	logic              we_n_q, we_n_d, re_n_q, re_n_d, oe_n_q, oe_n_d;
	logic [7:0]        ph_q, ph_d;
	logic              busy_seen_q, busy_seen_d;
	logic              done_q, done_d;
	logic              cycle_go, cycle_end;
	kind_t             kind;
	logic [7:0]        cyc_byte;

	stream_if #(.W(8)) fin ();
	stream_if #(.W(8)) fout ();

	// read data pass through the fifo; a full fifo stalls the read strobe
	byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.in_s    (fin.snk),
		.out_s   (fout.src)
	);
	assign rd_valid   = fout.valid;
	assign rd_data    = fout.data;
	assign fout.ready = rd_ready;
	assign fin.data   = io_in;

	function automatic logic [7:0] first_cmd(input op_t op);
		unique case (op)
			OP_READ, OP_COPY_RD:                 return CMD_READ;
			OP_CACHE_RD:                         return CMD_CACHE_RD;
			OP_CACHE_END:                        return CMD_CACHE_END;
			OP_COLCHG:                           return CMD_COLCHG;
			OP_PROG, OP_PROG_CACHE:              return CMD_PROG;
			OP_INCOL:                            return CMD_INCOL;
			OP_COPY_PROG, OP_COPY_PROG_LAST:     return CMD_COPY_PROG;
			OP_ERASE:                            return CMD_ERASE;
			OP_STATUS:                           return CMD_STATUS;
			OP_STATUS_MP:                        return CMD_STATUS_MP;
			default:                             return CMD_RESET;
		endcase
	endfunction

	function automatic logic [7:0] second_cmd(input op_t op);
		unique case (op)
			OP_READ:                             return CMD_READ_GO;
			OP_COPY_RD:                          return CMD_COPY_RD;
			OP_COLCHG:                           return CMD_COLCHG_GO;
			OP_PROG_CACHE, OP_COPY_PROG:         return CMD_PROG_CACHE;
			OP_ERASE:                            return CMD_ERASE_GO;
			default:                             return CMD_PROG_GO;
		endcase
	endfunction

	function automatic logic has_second(input op_t op);
		return op inside {OP_READ, OP_COPY_RD, OP_COLCHG, OP_PROG, OP_PROG_CACHE,
			OP_COPY_PROG, OP_COPY_PROG_LAST, OP_ERASE};
	endfunction

	function automatic logic is_busy_op(input op_t op);
		return op inside {OP_READ, OP_COPY_RD, OP_CACHE_RD, OP_CACHE_END, OP_PROG,
			OP_PROG_CACHE, OP_COPY_PROG, OP_COPY_PROG_LAST, OP_ERASE, OP_RESET};
	endfunction

	// while busy only the status and reset codes may go out
	assign req_ready = (st_q == S_IDLE) &&
		(ready_busy_n || req_op inside {OP_STATUS, OP_STATUS_MP, OP_RESET});

	// one strobe cycle: low phase then high phase, each PHASE_CYC long
	assign cycle_end = (ph_q == 8'(2 * PHASE_CYC - 1));
	assign kind = (st_q == S_ADDR) ? K_ADDR :
		(st_q == S_DATA_IN) ? K_DIN :
		(st_q == S_DATA_OUT) ? K_DOUT : K_CMD;
	assign cyc_byte = (st_q == S_CMD1) ? first_cmd(op_q) :
		(st_q == S_CMD2) ? second_cmd(op_q) : 8'h00;
	assign cycle_go = (st_q == S_CMD1) || (st_q == S_CMD2) || (st_q == S_ADDR) ||
		((st_q == S_DATA_IN) && (wr_valid || ph_q != 8'h00)) ||
		((st_q == S_DATA_OUT) && (fin.ready || ph_q != 8'h00));
	// a byte is taken from the user as its cycle starts and loads io_out
	assign wr_ready  = (st_q == S_DATA_IN) && (ph_q == 8'h00);
	// capture in the last low phase of the read strobe, while data stands
	assign fin.valid = (st_q == S_DATA_OUT) && (ph_q == 8'(PHASE_CYC));

	always_comb
	begin
		st_d        = st_q;
		op_d        = op_q;
		col_d       = col_q;
		row_d       = row_q;
		len_d       = len_q;
		idx_d       = idx_q;
		aend_d      = aend_q;
		out_d       = out_q;
		cs_n_d      = cs_n_q;
		cle_d       = 1'b0;
		ale_d       = 1'b0;
		we_n_d      = 1'b1;
		re_n_d      = 1'b1;
		oe_n_d      = oe_n_q;
		ph_d        = 8'h00;
		busy_seen_d = busy_seen_q;
		done_d      = 1'b0;
		if (cycle_go && !cycle_end)
			ph_d = ph_q + 8'h01;
		if (cycle_go)
		begin
			// hold the latch strobes through the whole cycle
			cle_d = (kind == K_CMD);
			ale_d = (kind == K_ADDR);
			if (kind == K_DOUT)
			begin
				re_n_d = (ph_q >= 8'(PHASE_CYC));
				oe_n_d = 1'b1;
			end
			else
			begin
				we_n_d = (ph_q >= 8'(PHASE_CYC));
				oe_n_d = 1'b0;
				out_d  = (kind == K_ADDR) ? addr_byte(col_q, row_q, idx_q) :
					(kind == K_DIN) ? (ph_q == 8'h00 ? wr_data : out_q) : cyc_byte;
			end
		end
		unique case (st_q)
			S_IDLE:
			begin
				oe_n_d = 1'b1;
				if (req_valid && req_ready)
				begin
					st_d   = S_CMD1;
					op_d   = req_op;
					col_d  = req_col;
					row_d  = req_row;
					len_d  = req_len;
					cs_n_d = 1'b0;
				end
				else if (ready_busy_n)
					cs_n_d = 1'b1;
			end
			S_CMD1:
				if (cycle_end)
				begin
					// erase skips the column bytes; 3-cycle row only
					idx_d  = (op_q == OP_ERASE) ? 3'(COL_CYCLES) : 3'd0;
					aend_d = (op_q inside {OP_COLCHG, OP_INCOL}) ? 3'(COL_CYCLES) :
						3'(ADDR_CYCLES);
					if (op_q inside {OP_STATUS, OP_STATUS_MP})
					begin
						len_d = LEN_W'(1);
						st_d  = S_DATA_OUT;
					end
					else if (op_q inside {OP_CACHE_RD, OP_CACHE_END, OP_RESET})
						st_d = S_WAIT_BUSY;
					else
						st_d = S_ADDR;
				end
			S_ADDR:
				if (cycle_end)
				begin
					idx_d = idx_q + 3'd1;
					if (idx_q + 3'd1 == aend_q)
					begin
						if (op_q inside {OP_PROG, OP_PROG_CACHE, OP_INCOL, OP_COPY_PROG,
							OP_COPY_PROG_LAST})
							st_d = (len_q != '0) ? S_DATA_IN : (has_second(op_q) ? S_CMD2 :
								S_FINISH);
						else
							st_d = S_CMD2;
					end
				end
			S_DATA_IN:
				if (cycle_end)
				begin
					len_d = len_q - LEN_W'(1);
					if (len_q == LEN_W'(1))
						st_d = has_second(op_q) ? S_CMD2 : S_FINISH;
				end
			S_CMD2:
				if (cycle_end)
				begin
					if (op_q == OP_COLCHG)
						st_d = (len_q != '0) ? S_DATA_OUT : S_FINISH;
					else
						st_d = S_WAIT_BUSY;
				end
			S_WAIT_BUSY:
			begin
				// confirm may not pull busy at once; allow a bounded window
				ph_d = ph_q + 8'h01;
				if (!ready_busy_n)
					busy_seen_d = 1'b1;
				if (busy_seen_q || ph_q == 8'hff)
					st_d = S_WAIT_READY;
			end
			S_WAIT_READY:
			begin
				busy_seen_d = 1'b0;
				// strobes rest high while busy, cs kept low
				if (ready_busy_n)
					st_d = (is_busy_op(op_q) && len_q != '0 &&
						op_q inside {OP_READ, OP_COPY_RD, OP_CACHE_RD, OP_CACHE_END}) ?
						S_DATA_OUT : S_FINISH;
			end
			S_DATA_OUT:
				if (cycle_end)
				begin
					len_d = len_q - LEN_W'(1);
					if (len_q == LEN_W'(1))
						st_d = S_FINISH;
				end
			S_FINISH:
			begin
				done_d = 1'b1;
				st_d   = S_IDLE;
			end
			default:
				st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q        <= S_IDLE;
			op_q        <= OP_READ;
			col_q       <= '0;
			row_q       <= '0;
			len_q       <= '0;
			idx_q       <= '0;
			aend_q      <= '0;
			out_q       <= 8'h00;
			cs_n_q      <= 1'b1;
			cle_q       <= 1'b0;
			ale_q       <= 1'b0;
			we_n_q      <= 1'b1;
			re_n_q      <= 1'b1;
			oe_n_q      <= 1'b1;
			ph_q        <= 8'h00;
			busy_seen_q <= 1'b0;
			done_q      <= 1'b0;
		end
		else
		begin
			st_q        <= st_d;
			op_q        <= op_d;
			col_q       <= col_d;
			row_q       <= row_d;
			len_q       <= len_d;
			idx_q       <= idx_d;
			aend_q      <= aend_d;
			out_q       <= out_d;
			cs_n_q      <= cs_n_d;
			cle_q       <= cle_d;
			ale_q       <= ale_d;
			we_n_q      <= we_n_d;
			re_n_q      <= re_n_d;
			oe_n_q      <= oe_n_d;
			ph_q        <= ph_d;
			busy_seen_q <= busy_seen_d;
			done_q      <= done_d;
		end
	end

	assign chip_select_n        = cs_n_q;
	assign command_latch_strobe = cle_q;
	assign address_latch_strobe = ale_q;
	assign write_strobe_n       = we_n_q;
	assign read_strobe_n        = re_n_q;
	assign io_out               = out_q;
	assign io_oe_n              = oe_n_q;
	assign done                 = done_q;
	// guard high only when user allows program/erase
	assign write_guard_n        = guard_enable;
endmodule
`default_nettype wire

// ==== rtl/nand_host_pkg.sv ====
// constants for the nand flash host controller
// assumes a single 25 MHz system clock
package nand_host_pkg;
	localparam int unsigned CLK_MHZ      = 25;
	localparam int unsigned PAGE_MAIN    = 4096;
	localparam int unsigned PAGE_SPARE   = 256;
	localparam int unsigned PAGE_BYTES   = PAGE_MAIN + PAGE_SPARE;
	localparam int unsigned BLOCK_PAGES  = 64;
	localparam int unsigned BLOCK_COUNT  = 2048;
	localparam int unsigned COL_W        = 13;
	localparam int unsigned ROW_W        = 17;
	localparam int unsigned PAGE_BITS    = 6;
	localparam int unsigned ADDR_CYCLES  = 5;
	localparam int unsigned COL_CYCLES   = 2;
	localparam int unsigned ROW_CYCLES   = 3;
	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_READ_GO   = 8'h30;
	localparam logic [7:0] CMD_COLCHG    = 8'h05;
	localparam logic [7:0] CMD_COLCHG_GO = 8'he0;
	localparam logic [7:0] CMD_CACHE_RD  = 8'h31;
	localparam logic [7:0] CMD_CACHE_END = 8'h3f;
	localparam logic [7:0] CMD_PROG      = 8'h80;
	localparam logic [7:0] CMD_PROG_GO   = 8'h10;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_INCOL     = 8'h85;
	localparam logic [7:0] CMD_COPY_RD   = 8'h3a;
	localparam logic [7:0] CMD_COPY_PROG = 8'h8c;
	localparam logic [7:0] CMD_ERASE     = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO  = 8'hd0;
	localparam logic [7:0] CMD_STATUS    = 8'h70;
	localparam logic [7:0] CMD_STATUS_MP = 8'h71;
	localparam logic [7:0] CMD_RESET     = 8'hff;
	// strobe phase: each half of a strobe pulse lasts this long
	localparam int unsigned T_PHASE_NS   = 40;
	localparam int unsigned PHASE_CYC    = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned FIFO_DEPTH   = 8;

	typedef enum logic [3:0] {
		OP_READ,
		OP_CACHE_RD,
		OP_CACHE_END,
		OP_COLCHG,
		OP_PROG,
		OP_PROG_CACHE,
		OP_INCOL,
		OP_COPY_RD,
		OP_COPY_PROG,
		OP_COPY_PROG_LAST,
		OP_ERASE,
		OP_STATUS,
		OP_STATUS_MP,
		OP_RESET
	} op_t;

	// column byte pair then three row bytes, upper lines forced low
	function automatic logic [7:0] addr_byte(input logic [COL_W-1:0] col,
		input logic [ROW_W-1:0] row, input logic [2:0] idx);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			3'd0: b = col[7:0];
			3'd1: b = {3'b000, col[12:8]};
			3'd2: b = row[7:0];
			3'd3: b = row[15:8];
			3'd4: b = {7'b0000000, row[16]};
			default: b = 8'h00;
		endcase
		return b;
	endfunction
endpackage

// ==== rtl/stream_if.sv ====
// valid/ready byte stream carrier between the host modules
// assumes both ends share clk_sys
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int unsigned W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/byte_fifo.sv ====
// synchronous fifo with valid/ready on both sides, registered read data
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic clk_sys,
	input  wire logic resetn,
	stream_if.snk     in_s,
	stream_if.src     out_s
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic [W-1:0]  dout_q, dout_d;
	logic          dv_q, dv_d;
	logic          push, pop;

	// one output register in front of the array; cnt_q leaves it out, so DEPTH+1 bytes fit
	assign in_s.ready  = (cnt_q != (AW+1)'(DEPTH));
	assign push        = in_s.valid && in_s.ready;
	assign pop         = (cnt_q != '0) && (!dv_q || out_s.ready);
	assign out_s.valid = dv_q;
	assign out_s.data  = dout_q;

	always_comb
	begin
		wr_d   = push ? AW'(wr_q + 1'b1) : wr_q;
		rd_d   = pop ? AW'(rd_q + 1'b1) : rd_q;
		cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		dout_d = pop ? mem_q[rd_q] : dout_q;
		dv_d   = pop ? 1'b1 : (out_s.ready ? 1'b0 : dv_q);
	end

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem_q[wr_q] <= in_s.data;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q   <= '0;
			rd_q   <= '0;
			cnt_q  <= '0;
			dout_q <= '0;
			dv_q   <= 1'b0;
		end
		else
		begin
			wr_q   <= wr_d;
			rd_q   <= rd_d;
			cnt_q  <= cnt_d;
			dout_q <= dout_d;
			dv_q   <= dv_d;
		end
	end
endmodule
`default_nettype wire

// ==== verification/nand_host_asserts.sv ====
// pin-level checker for the nand host, bound to its top module
// assumes strobes are registered on clk_sys
`timescale 1ns/1ps
`default_nettype none
module nand_host_asserts (
	input wire logic       clk_sys,
	input wire logic       resetn,
	input wire logic       chip_select_n,
	input wire logic       command_latch_strobe,
	input wire logic       address_latch_strobe,
	input wire logic       write_strobe_n,
	input wire logic       read_strobe_n,
	input wire logic       write_guard_n,
	input wire logic       ready_busy_n,
	input wire logic [7:0] io_out,
	input wire logic       io_oe_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic       we_q;
	logic [2:0] acnt_q, acnt_d;
	logic [7:0] cmd_q, cmd_d;
	logic       rise;
	// index of the address cycle in progress, counted from the last command
	always_comb
	begin
		rise = write_strobe_n && !we_q;
		acnt_d = acnt_q;
		cmd_d = cmd_q;
		if (rise && command_latch_strobe)
		begin
			acnt_d = 3'd0;
			cmd_d = io_out;
		end
		else if (rise && address_latch_strobe && acnt_q != 3'd7)
			acnt_d = acnt_q + 3'd1;
	end
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn)
		begin
			we_q <= 1'b1;
			acnt_q <= 3'd0;
			cmd_q <= 8'h00;
		end
		else
		begin
			we_q <= write_strobe_n;
			acnt_q <= acnt_d;
			cmd_q <= cmd_d;
		end
	chk_latch_excl: assert property (!(command_latch_strobe && address_latch_strobe))
		else $error("both latch strobes high");
	chk_strobe_cross: assert property (write_strobe_n || read_strobe_n)
		else $error("write and read strobes low together");
	chk_write_hold: assert property ($rose(write_strobe_n) |-> $stable(io_out)
		&& $stable(command_latch_strobe) && $stable(address_latch_strobe))
		else $error("bus or latch strobe moved at write strobe rise");
	chk_we_drive: assert property ($fell(write_strobe_n) |-> !io_oe_n ##1 write_strobe_n)
		else $error("write phase not driven or too long");
	chk_read_release: assert property (!read_strobe_n |-> io_oe_n
		&& !command_latch_strobe && !address_latch_strobe)
		else $error("host drives bus during read strobe");
	chk_addr_count: assert property (address_latch_strobe && !write_strobe_n |-> acnt_q < 3'd5)
		else $error("more than five address cycles");
	chk_col_upper: assert property (address_latch_strobe && !write_strobe_n && acnt_q == 3'd1
		&& cmd_q != 8'h60 |-> io_out[7:5] == 3'b000)
		else $error("second address cycle upper lines not low");
	chk_row_upper: assert property (address_latch_strobe && !write_strobe_n
		&& acnt_q == 3'd4 |-> io_out[7:1] == 7'h00)
		else $error("fifth address cycle upper lines not low");
	chk_busy_cmds: assert property (command_latch_strobe && !write_strobe_n && !ready_busy_n
		|-> io_out inside {8'h70, 8'h71, 8'hff})
		else $error("command other than status or reset while busy");
	chk_busy_quiet: assert property (!ready_busy_n && !chip_select_n && !command_latch_strobe
		|-> write_strobe_n)
		else $error("address or data cycle while busy");
	chk_data_guard: assert property (!command_latch_strobe && !address_latch_strobe
		&& !chip_select_n && !write_strobe_n |-> write_guard_n)
		else $error("data input with write guard low");
endmodule
bind nand_host nand_host_asserts nand_host_asserts_inst (.clk_sys, .resetn, .chip_select_n,
	.command_latch_strobe, .address_latch_strobe, .write_strobe_n, .read_strobe_n,
	.write_guard_n, .ready_busy_n, .io_out, .io_oe_n);
`default_nettype wire

// ==== verification/nand_dev_model.sv ====
// behavioural flash device reacting to the strobe edges
// assumes the host registers its strobes; busy time is a plain delay
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
	// off the 40 ns grid so ready never rises on a sampling edge
	parameter int         BUSY_NS    = 2010,
	parameter logic [7:0] STAT_READY = 8'he0
) (
	input wire logic        chip_select_n,
	input wire logic        command_latch_strobe,
	input wire logic        address_latch_strobe,
	input wire logic        write_strobe_n,
	input wire logic        read_strobe_n,
	input wire logic        write_guard_n,
	input wire logic  [7:0] io_out,
	output var logic        ready_busy_n,
	output logic      [7:0] io_in
);
	logic [7:0]  mem[logic [29:0]];
	logic [7:0]  cq[$];
	logic [12:0] col_q = 13'h0000;
	logic [16:0] row_q = 17'h00000;
	logic [7:0]  dout_q = 8'h00;
	logic        stat_q = 1'b0;
	int          naddr = 0, apos = 0, erase_cnt = 0, nout = 0;
	initial ready_busy_n = 1'b1;
	// released bus shows the inverse so a stale capture cannot pass
	assign io_in = (!chip_select_n && !command_latch_strobe && !address_latch_strobe
		&& write_strobe_n && !read_strobe_n) ? dout_q : ~dout_q;
	task automatic go_busy();
		fork
			begin
				ready_busy_n = 1'b0;
				#(BUSY_NS) ready_busy_n = 1'b1;
			end
		join_none
	endtask
	// cs is not looked at for busy: a running operation keeps going
	always @(posedge write_strobe_n)
		if (!chip_select_n && read_strobe_n)
		begin
			if (command_latch_strobe && !address_latch_strobe)
			begin
				if (ready_busy_n || io_out inside {8'h70, 8'h71, 8'hff})
				begin
					cq.push_back(io_out);
					stat_q = io_out inside {8'h70, 8'h71};
					apos = (io_out == 8'h60) ? 2 : 0;
					if (io_out inside {8'h30, 8'h31, 8'h3f, 8'h3a, 8'hff})
						go_busy();
					if (io_out inside {8'h10, 8'h15, 8'hd0} && write_guard_n)
					begin
						erase_cnt += (io_out == 8'hd0);
						go_busy();
					end
				end
			end
			// address accepted without a prior 00, as after power-on
			else if (!command_latch_strobe && address_latch_strobe && ready_busy_n)
			begin
				naddr++;
				case (apos)
					0: col_q[7:0] = io_out;
					1: col_q[12:8] = io_out[4:0];
					2: row_q[7:0] = io_out;
					3: row_q[15:8] = io_out;
					default: row_q[16] = io_out[0];
				endcase
				apos++;
			end
			else if (!command_latch_strobe && !address_latch_strobe && write_guard_n)
			begin
				mem[{row_q, col_q}] = io_out;
				col_q++;
			end
		end
	always @(negedge read_strobe_n)
		if (!chip_select_n && !command_latch_strobe && !address_latch_strobe && write_strobe_n)
		begin
			nout++;
			if (stat_q)
				dout_q = ready_busy_n ? STAT_READY : (STAT_READY & 8'hbf);
			else
			begin
				dout_q = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : col_q[7:0] ^ row_q[7:0];
				col_q++;
			end
		end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench: nand host driving the behavioural flash model
// assumes package, stream carrier, fifo and host compile first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import nand_host_pkg::*;
	logic             clk_sys, resetn, req_valid, wr_valid, rd_ready, guard_enable, wr_take;
	op_t              req_op;
	logic [COL_W-1:0] req_col;
	logic [ROW_W-1:0] req_row;
	logic [12:0]      req_len;
	logic [7:0]       wr_data, rd_data, io_out, io_in;
	logic             req_ready, wr_ready, rd_valid, done, chip_select_n, command_latch_strobe;
	logic             address_latch_strobe, write_strobe_n, read_strobe_n, write_guard_n;
	logic             ready_busy_n, io_oe_n;
	logic [7:0]       wq[$], rq[$], c[$];
	int               failures, num_checks, cycles;

	nand_host nand_host_inst (.clk_sys, .resetn, .req_valid, .req_ready, .req_op, .req_col,
		.req_row, .req_len, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data,
		.done, .guard_enable, .chip_select_n, .command_latch_strobe, .address_latch_strobe,
		.write_strobe_n, .read_strobe_n, .write_guard_n, .ready_busy_n, .io_in, .io_out,
		.io_oe_n);
	nand_dev_model nand_dev_model_inst (.chip_select_n, .command_latch_strobe,
		.address_latch_strobe, .write_strobe_n, .read_strobe_n, .write_guard_n, .io_out,
		.ready_busy_n, .io_in);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// sample handshakes mid-cycle; read bytes are stored at once, the write pop waits for the next rising edge
	always @(negedge clk_sys)
	begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
			rq.push_back(rd_data);
		wr_take = (wr_valid === 1'b1 && wr_ready === 1'b1);
	end
	always @(posedge clk_sys)
	begin
		if (wr_take)
			void'(wq.pop_front());
		wr_valid <= (wq.size() != 0);
		wr_data <= (wq.size() != 0) ? wq[0] : 8'h00;
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic issue(input op_t op, input logic [COL_W-1:0] col,
		input logic [ROW_W-1:0] row, input logic [12:0] len);
		int n;
		n = 0;
		req_op <= op;
		req_col <= col;
		req_row <= row;
		req_len <= len;
		req_valid <= 1'b1;
		@(negedge clk_sys);
		while (req_ready !== 1'b1 && n < 2000)
		begin
			n++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		req_valid <= 1'b0;
		check(32'(n < 2000), 32'd1);
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		@(negedge clk_sys);
		while (done !== 1'b1 && n < 3000)
		begin
			n++;
			@(negedge clk_sys);
		end
		@(posedge clk_sys);
		check(32'(n < 3000), 32'd1);
	endtask

	task automatic t_cmds();
		op_t         ops[13] = '{OP_READ, OP_CACHE_RD, OP_CACHE_END, OP_COLCHG, OP_PROG_CACHE,
			OP_INCOL, OP_COPY_RD, OP_COPY_PROG, OP_COPY_PROG_LAST, OP_ERASE, OP_STATUS,
			OP_STATUS_MP, OP_RESET};
		logic [15:0] cmd[13] = '{16'h0030, 16'h3100, 16'h3f00, 16'h05e0, 16'h8015, 16'h8500,
			16'h003a, 16'h8c15, 16'h8c10, 16'h60d0, 16'h7000, 16'h7100, 16'hff00};
		int          nc[13] = '{2, 1, 1, 2, 2, 1, 2, 2, 2, 2, 1, 1, 1};
		int          na[13] = '{5, 0, 0, 2, 5, 2, 5, 5, 5, 3, 0, 0, 0};
		for (int i = 0; i < 13; i++)
		begin
			nand_dev_model_inst.cq.delete();
			nand_dev_model_inst.naddr = 0;
			rq.delete();
			issue(ops[i], 13'h0123, 17'h00abc, 13'h0000);
			wait_done();
			c = nand_dev_model_inst.cq;
			check(32'(c.size()), 32'(nc[i]));
			check({16'h0000, c[0], (c.size() > 1) ? c[1] : 8'h00}, {16'h0000, cmd[i]});
			check(32'(nand_dev_model_inst.naddr), 32'(na[i]));
			if (cmd[i][15:12] == 4'h7)
				check(32'(rq[0]), 32'h00e0);
		end
	endtask
	task automatic t_prog_read();
		logic [7:0] pat[4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
		foreach (pat[i])
			wq.push_back(pat[i]);
		issue(OP_PROG, 13'h10fc, 17'h1ffff, 13'h0004);
		wait_done();
		check(32'(nand_dev_model_inst.col_q), 32'h1100);
		check(32'(nand_dev_model_inst.row_q), 32'h1ffff);
		rq.delete();
		issue(OP_READ, 13'h10fc, 17'h1ffff, 13'h0004);
		wait_done();
		check(32'(rq.size()), 32'd4);
		foreach (pat[i])
			check(32'(rq[i]), 32'(pat[i]));
	endtask
	task automatic t_stall();
		int n;
		rd_ready <= 1'b0;
		rq.delete();
		nand_dev_model_inst.nout = 0;
		issue(OP_READ, 13'h0000, 17'h00045, 13'd20);
		repeat (300) @(posedge clk_sys);
		n = nand_dev_model_inst.nout;
		check(32'(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2), 32'd1);
		rd_ready <= 1'b1;
		wait_done();
		check(32'(rq.size()), 32'd20);
		foreach (rq[i])
			check(32'(rq[i]), 32'(i ^ 8'h45));
	endtask
	task automatic t_guard();
		int e;
		e = nand_dev_model_inst.erase_cnt;
		guard_enable <= 1'b0;
		issue(OP_ERASE, 13'h0000, 17'h00040, 13'h0000);
		check(32'(write_guard_n), 32'd0);
		wait_done();
		check(32'(nand_dev_model_inst.erase_cnt), 32'(e));
		guard_enable <= 1'b1;
		issue(OP_ERASE, 13'h0000, 17'h00040, 13'h0000);
		wait_done();
		check(32'(nand_dev_model_inst.erase_cnt), 32'(e + 1));
	endtask

	initial
	begin
		resetn = 1'b0;
		req_valid = 1'b0;
		wr_valid = 1'b0;
		rd_ready = 1'b1;
		guard_enable = 1'b1;
		req_op = OP_READ;
		req_col = '0;
		req_row = '0;
		req_len = '0;
		wr_data = 8'h00;
		wr_take = 1'b0;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		t_cmds();
		t_prog_read();
		t_stall();
		t_guard();
		summarize();
	end
endmodule
`default_nettype wire
